/* inc/gst_pkg.sv */
// Package of register map, field positions and reset values for the gated 16-bit timer
package gst_pkg;
    // Register byte offsets (AXI4-Lite, one word each)
    localparam logic [4:0] OFF_TIMER_CTRL = 5'h00;
    localparam logic [4:0] OFF_GATE_CTRL  = 5'h04;
    localparam logic [4:0] OFF_COUNT_LOW  = 5'h08;
    localparam logic [4:0] OFF_COUNT_HIGH = 5'h0c;
    localparam logic [4:0] OFF_FLAGS      = 5'h10;
    localparam logic [4:0] OFF_MASK       = 5'h14;
    localparam logic [4:0] OFF_OSC_CTRL   = 5'h18;

    // timer_control_reg fields
    localparam int TC_ON_BIT       = 0;
    localparam int TC_WIDE_BIT     = 1;
    localparam int TC_PRE_LSB      = 4;
    localparam int TC_OSCEN_BIT    = 3;
    localparam int TC_CS_BIT       = 6;
    // gate_control_reg fields
    localparam int GC_POL_BIT      = 6;
    localparam int GC_EN_BIT       = 7;
    localparam int GC_VAL_BIT      = 2;
    // osc_control_two fields
    localparam int OC_FORCE_BIT    = 3;
    localparam int OC_OTHER_LSB    = 0;
    // peripheral_flags_two fields
    localparam int FL_GATE_BIT     = 0;
    localparam int FL_OVF_BIT      = 1;

    localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
    localparam logic [7:0] GATE_CTRL_RST  = 8'h00;
    localparam logic [7:0] OSC_CTRL_RST   = 8'h00;
    localparam logic [1:0] FLAGS_RST      = 2'h0;
    localparam logic [1:0] MASK_RST       = 2'h0;
    localparam logic [15:0] COUNT_RST     = 16'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* inc/gst_count_if.sv */
// Interface carrying count requests between register front end and counter core
`timescale 1ns/1ps
interface gst_count_if;
    logic        tick;
    logic        wr_low;
    logic        wr_high;
    logic        wide;
    logic [7:0]  wdata;
    logic [15:0] count;
    logic        ovf;
    modport core (input tick, wr_low, wr_high, wide, wdata, output count, ovf);
    modport ctrl (output tick, wr_low, wr_high, wide, wdata, input count, ovf);
endinterface

/* rtl/gst_counter.sv */
// Counter core: 16-bit count with wide-access write commit
`timescale 1ns/1ps
module gst_counter
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control side
    gst_count_if.core cif,
    // Shadow byte for wide writes
    input  wire logic [7:0] shadow
);
    logic [15:0] count;
    logic        ovf;

    assign cif.count = count;
    assign cif.ovf   = ovf;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= gst_pkg::COUNT_RST;
            ovf   <= 1'b0;
        end
        else
        begin
            ovf <= 1'b0;
            if (cif.wr_low)
            begin
                if (cif.wide)
                    count <= {shadow, cif.wdata};
                else
                    count[7:0] <= cif.wdata;
            end
            else if (cif.wr_high && !cif.wide)
                count[15:8] <= cif.wdata;
            else if (cif.tick)
            begin
                count <= count + 16'h0001;
                ovf   <= (count == 16'hffff);
            end
        end
    end
endmodule

/* rtl/gst_timer.sv */
// Gated 16-bit timer with AXI4-Lite register access
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - With wide access selected, the high-byte address reaches a shadow byte.
// - In wide mode, reading the low byte copies the live high byte into the shadow.
// - In wide mode, writing the low byte also loads the live high byte from the shadow.
// - In wide mode, high-byte reads and writes touch only the shadow.
// - Writing the low byte clears the prescaler; writing the high byte does not.
// - The secondary oscillator runs when any of four timer enables or the force-on bit is set.
// - With the oscillator selected, count on each rising edge of that oscillator.
// - Gate enable makes counting depend on the gate input; clear means free counting.
// - Polarity 0 counts while gate low, polarity 1 counts while gate high.
// - While the gate permits, count on each rising edge of the selected clock.
// - While the gate blocks, hold the count.
// - Overflow sets a sticky flag that software clears.
// - A gate event sets a sticky flag that software clears.
module gst_timer
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic        gate_input_pin,
    input  wire logic        secondary_oscillator,
    input  wire logic [2:0]  sec_osc_enable_others,
    output logic             sec_osc_run,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  timer_control_reg;
    logic [7:0]  gate_control_reg;
    logic [7:0]  osc_control_two;
    logic [1:0]  peripheral_flags_two;
    logic [1:0]  irq_mask;
    logic [7:0]  shadow;
    logic [2:0]  prescale;
    logic [1:0]  gate_sync;
    logic [1:0]  osc_sync;
    logic [2:0]  others_s1;
    logic [2:0]  others_s2;
    logic        osc_prev;
    logic        count_en_prev;

    gst_count_if cif ();

    gst_counter u_counter
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cif     (cif),
        .shadow  (shadow)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: write address and data may arrive in either order
    logic        aw_held;
    logic        w_held;
    logic [4:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic        wr_ok;
    logic        rd_fire;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign wr_ok         = (aw_addr <= gst_pkg::OFF_OSC_CTRL) && (aw_addr[1:0] == 2'b00);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 5'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= gst_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Byte lane 0 carries every register; upper lanes are ignored
    logic we;
    assign we = wr_fire && wr_ok && w_strb[0];

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_control_reg <= gst_pkg::TIMER_CTRL_RST;
            gate_control_reg  <= gst_pkg::GATE_CTRL_RST;
            osc_control_two   <= gst_pkg::OSC_CTRL_RST;
            irq_mask          <= gst_pkg::MASK_RST;
        end
        else if (we)
        begin
            case (aw_addr)
                gst_pkg::OFF_TIMER_CTRL: timer_control_reg <= w_data[7:0];
                gst_pkg::OFF_GATE_CTRL:  gate_control_reg  <= w_data[7:0];
                gst_pkg::OFF_OSC_CTRL:   osc_control_two   <= w_data[7:0];
                gst_pkg::OFF_MASK:       irq_mask          <= w_data[1:0];
                default:                 irq_mask          <= irq_mask;
            endcase
        end
    end

    logic wide;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    assign wide    = timer_control_reg[gst_pkg::TC_WIDE_BIT];
    assign wr_low  = we && (aw_addr == gst_pkg::OFF_COUNT_LOW);
    assign wr_high = we && (aw_addr == gst_pkg::OFF_COUNT_HIGH);
    assign rd_low  = rd_fire && (s_axi_araddr == gst_pkg::OFF_COUNT_LOW);

    // Shadow byte: captured on low-byte read, written at the high address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            shadow <= 8'h00;
        else if (wide && wr_high)
            shadow <= w_data[7:0];
        else if (wide && rd_low)
            shadow <= cif.count[15:8];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gate_sync <= 2'b00;
            osc_sync  <= 2'b00;
            others_s1 <= 3'h0;
            others_s2 <= 3'h0;
        end
        else
        begin
            gate_sync <= {gate_sync[0], gate_input_pin};
            osc_sync  <= {osc_sync[0], secondary_oscillator};
            others_s1 <= sec_osc_enable_others;
            others_s2 <= others_s1;
        end
    end

    // Oscillator runs if any timer enable or the force-on bit asks for it
    assign sec_osc_run = timer_control_reg[gst_pkg::TC_OSCEN_BIT] | (|others_s2)
                       | osc_control_two[gst_pkg::OC_FORCE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Count source and gate
    logic osc_rise;
    logic src_edge;
    logic gate_open;
    logic count_en;
    logic [2:0] pre_sel;
    logic pre_hit;

    assign osc_rise  = osc_sync[1] && !osc_prev;
    // Secondary oscillator only counts while it is running
    assign src_edge  = timer_control_reg[gst_pkg::TC_CS_BIT] ? (osc_rise && sec_osc_run)
                                                             : 1'b1;
    // Gate is ignored when the enable is clear
    assign gate_open = !gate_control_reg[gst_pkg::GC_EN_BIT]
                     || (gate_sync[1] == gate_control_reg[gst_pkg::GC_POL_BIT]);
    assign count_en  = timer_control_reg[gst_pkg::TC_ON_BIT] && gate_open;
    assign pre_sel   = {1'b0, timer_control_reg[gst_pkg::TC_PRE_LSB +: 2]};
    assign pre_hit   = ((prescale + 3'h1) & ((3'h1 << pre_sel[1:0]) - 3'h1)) == 3'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc_prev  <= 1'b0;
        end
        else
        begin
            osc_prev  <= osc_sync[1];
        end
    end

    // Prescaler divides by 1, 2, 4 or 8; low-byte write restarts it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            prescale <= 3'h0;
        else if (wr_low)
            prescale <= 3'h0;
        else if (count_en && src_edge)
            prescale <= prescale + 3'h1;
    end

    assign cif.tick    = count_en && src_edge && pre_hit;
    assign cif.wr_low  = wr_low;
    assign cif.wr_high = wr_high;
    assign cif.wide    = wide;
    assign cif.wdata   = w_data[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags and interrupt; set wins over write-zero clear
    logic gate_event;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_en_prev <= 1'b0;
        else
            count_en_prev <= gate_control_reg[gst_pkg::GC_EN_BIT] && gate_open;
    end
    // Gate window closing is the gate event
    assign gate_event = count_en_prev && !(gate_control_reg[gst_pkg::GC_EN_BIT] && gate_open);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            peripheral_flags_two <= gst_pkg::FLAGS_RST;
        else
        begin
            if (we && aw_addr == gst_pkg::OFF_FLAGS)
                peripheral_flags_two <= peripheral_flags_two & w_data[1:0];
            if (cif.ovf)
                peripheral_flags_two[gst_pkg::FL_OVF_BIT] <= 1'b1;
            if (gate_event)
                peripheral_flags_two[gst_pkg::FL_GATE_BIT] <= 1'b1;
        end
    end

    assign irq = |(peripheral_flags_two & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    logic [7:0] rd_val;
    logic       rd_ok;
    always_comb
    begin
        rd_val = 8'h00;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            gst_pkg::OFF_TIMER_CTRL: rd_val = timer_control_reg;
            gst_pkg::OFF_GATE_CTRL:  rd_val = {gate_control_reg[7:3], gate_sync[1],
                                               gate_control_reg[1:0]};
            gst_pkg::OFF_COUNT_LOW:  rd_val = cif.count[7:0];
            gst_pkg::OFF_COUNT_HIGH: rd_val = wide ? shadow : cif.count[15:8];
            gst_pkg::OFF_FLAGS:      rd_val = {6'h00, peripheral_flags_two};
            gst_pkg::OFF_MASK:       rd_val = {6'h00, irq_mask};
            gst_pkg::OFF_OSC_CTRL:   rd_val = osc_control_two;
            default:                 rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= gst_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_val};
            s_axi_rresp  <= rd_ok ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

/* testbench/gst_timer_asserts.sv */
// Checker of bus handshakes and oscillator request of the timer
`timescale 1ns/1ps
module gst_timer_asserts
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pins
    input wire logic [2:0]  sec_osc_enable_others,
    input wire logic        sec_osc_run,
    input wire logic        irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during pending read");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("response not held");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during pending response");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_err_data: assert property (s_axi_rvalid && s_axi_rresp == gst_pkg::RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read with data");
    a_osc_request: assert property ((sec_osc_enable_others != 3'h0) [*4] |-> sec_osc_run)
        else $error("oscillator not requested");

    c_err: cover property (s_axi_rvalid && s_axi_rresp == gst_pkg::RESP_SLVERR);
    c_irq: cover property ($rose(irq));
    c_osc: cover property ($rose(sec_osc_run));
endmodule
bind gst_timer gst_timer_asserts gst_timer_asserts_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sec_osc_enable_others, .sec_osc_run, .irq);

/* testbench/tb.sv */
// Self-checking bench of the gated 16-bit timer over its register bus
`timescale 1ns/1ps
module tb;
    localparam logic [4:0] TC = gst_pkg::OFF_TIMER_CTRL;
    localparam logic [4:0] GC = gst_pkg::OFF_GATE_CTRL;
    localparam logic [4:0] LO = gst_pkg::OFF_COUNT_LOW;
    localparam logic [4:0] HI = gst_pkg::OFF_COUNT_HIGH;
    localparam logic [4:0] FL = gst_pkg::OFF_FLAGS;
    localparam logic [4:0] MK = gst_pkg::OFF_MASK;
    localparam logic [4:0] OC = gst_pkg::OFF_OSC_CTRL;
    localparam logic [4:0] OFFS [7] = '{TC, GC, LO, HI, FL, MK, OC};
    localparam logic [31:0] SE = {30'h0, gst_pkg::RESP_SLVERR};
    logic        aclk;
    logic        aresetn;
    logic [4:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [4:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        gate;
    logic        osc;
    logic [2:0]  others;
    logic        run;
    logic        irq;
    logic [31:0] v;
    logic [31:0] w;
    logic [31:0] rr;
    logic [31:0] br;
    int          n_mismatch;
    int          compares;
    int          cyc;

    gst_timer gst_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .gate_input_pin(gate), .secondary_oscillator(osc),
        .sec_osc_enable_others(others), .sec_osc_run(run), .irq(irq));

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                br = {30'h0, bresp};
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                rr = {30'h0, rresp};
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    // Slow enough that the two-stage synchroniser sees every level
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            osc <= 1'b1;
            repeat (6) @(posedge aclk);
            osc <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever
            #12.5 aclk = ~aclk;
    end

    // Whole run needs about 520 cycles
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial
    begin
        {aresetn, awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, gate, osc, others} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (OFFS[i])
            rdchk(OFFS[i], 32'h0);
        rd(5'h1c, v);
        chk(rr, SE);
        wr(5'h1c, 8'hff);
        chk(br, SE);
        // Wide mode with the timer stopped, so the count cannot move
        wr(TC, 8'h02);
        wr(HI, 8'hab);
        rdchk(HI, 32'hab);
        wr(LO, 8'hcd);
        rdchk(LO, 32'hcd);
        rdchk(HI, 32'hab);
        wr(HI, 8'h55);
        rdchk(LO, 32'hcd);
        rdchk(HI, 32'hab);
        // Overflow and interrupt
        wr(TC, 8'h00);
        wr(LO, 8'hf0);
        wr(HI, 8'hff);
        wr(MK, 8'h02);
        wr(TC, 8'h01);
        repeat (40) @(posedge aclk);
        wr(TC, 8'h00);
        rdchk(HI, 32'h0);
        rdchk(FL, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(MK, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(MK, 8'h02);
        wr(FL, 8'h02);
        rdchk(FL, 32'h2);
        wr(FL, 8'h00);
        rdchk(FL, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Gate: hold, free run, count while high, event on closing
        @(posedge aclk);
        gate <= 1'b1;
        wr(LO, 8'h00);
        wr(GC, 8'h80);
        wr(TC, 8'h01);
        repeat (20) @(posedge aclk);
        rdchk(LO, 32'h0);
        rdchk(GC, 32'h84);
        wr(GC, 8'h00);
        repeat (5) @(posedge aclk);
        rd(LO, v);
        chk({31'h0, v != 32'h0}, 32'h1);
        wr(GC, 8'hc0);
        wr(FL, 8'h00);
        rd(LO, v);
        repeat (4) @(posedge aclk);
        rd(LO, w);
        chk({31'h0, w > v}, 32'h1);
        @(posedge aclk);
        gate <= 1'b0;
        repeat (6) @(posedge aclk);
        rd(LO, v);
        repeat (6) @(posedge aclk);
        rdchk(LO, v);
        rdchk(FL, 32'h1);
        // Count from the secondary oscillator
        wr(TC, 8'h00);
        wr(GC, 8'h00);
        wr(LO, 8'h00);
        wr(TC, 8'h49);
        pulse(5);
        rdchk(LO, 32'h5);
        chk({31'h0, run}, 32'h1);
        wr(TC, 8'h00);
        chk({31'h0, run}, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge aclk);
            others <= 3'(1 << i);
            repeat (4) @(posedge aclk);
            chk({31'h0, run}, 32'h1);
            others <= 3'h0;
            repeat (4) @(posedge aclk);
            chk({31'h0, run}, 32'h0);
        end
        wr(OC, 8'h08);
        chk({31'h0, run}, 32'h1);
        wr(OC, 8'h00);
        // Divide by two: a low write restarts the prescaler; the high write comes at prescaler 2, where a restart would not change the count
        wr(TC, 8'h59);
        wr(LO, 8'h00);
        pulse(4);
        rdchk(LO, 32'h2);
        pulse(1);
        wr(LO, 8'h00);
        pulse(1);
        rdchk(LO, 32'h0);
        pulse(1);
        wr(HI, 8'h00);
        pulse(1);
        rdchk(LO, 32'h1);
        wr(TC, 8'h00);
        tally_and_finish();
    end
endmodule
